// file: shared/dma_crc_pkg.sv
package dma_crc_pkg;
	// Register byte offsets on the AHB-Lite slave.
	localparam logic [7:0] off_error_status = 8'h00;
	localparam logic [7:0] off_error_address = 8'h04;
	localparam logic [7:0] off_crc_control = 8'h08;
	localparam logic [7:0] off_crc_value = 8'h0c;
	localparam logic [7:0] off_crc_taps = 8'h10;
	localparam logic [7:0] off_data_in = 8'h14;
	localparam logic [7:0] off_data_out = 8'h18;
	// Error status fields.
	localparam int err_dir_bit = 31;
	localparam int err_ch_lsb = 0;
	// CRC control fields.
	localparam int byte_order_select_lsb = 28;
	localparam int wbo_bit = 27;
	localparam int bit_reflect_select_bit = 24;
	localparam int poly_length_field_lsb = 8;
	localparam int crc_route_enable_bit = 7;
	localparam int app_bit = 6;
	localparam int typ_bit = 5;
	localparam int ch_lsb = 0;
	localparam logic [31:0] crc_control_mask = 32'h39001fe7;
	localparam logic [31:0] reset_word = 32'h00000000;
	localparam int max_poly_len = 32;
	// Byte order encodings.
	localparam logic [1:0] byte_order_select_none = 2'h0;
	localparam logic [1:0] byte_order_select_word = 2'h1;
	localparam logic [1:0] byte_order_select_half = 2'h2;
	localparam logic [1:0] byte_order_select_half_bytes = 2'h3;
	localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage

// file: verilog/dma_error_capture_crc_config.sv
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module dma_error_capture_crc_config (
	input wire logic clk, // System clock, 40 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready in.
	output logic [31:0] hrdata, // Read data.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Always OKAY.
	input wire logic rd_err, // A channel read access faulted.
	input wire logic [31:0] rd_err_addr, // Address of that read.
	input wire logic wr_err, // A channel write access faulted.
	input wire logic [31:0] wr_err_addr, // Address of that write.
	input wire logic [2:0] active_channel, // Most recently active channel.
	input wire logic [2:0] xfer_channel, // Channel owning the data beat.
	input wire logic xfer_valid, // Source data beat is present.
	input wire logic [31:0] xfer_data, // Source data beat.
	input wire logic block_done, // Channel block transfer completed.
	input wire logic [31:0] channel_dest_start, // Destination start of the CRC channel.
	output logic dest_valid, // Destination write strobe.
	output logic [31:0] dest_data, // Destination write data.
	output logic [31:0] dest_addr, // Destination address for the CRC append write.
	output logic dest_is_crc, // Destination write carries the CRC result.
	output logic crc_channel_active // Engine is enabled on the beat's channel.
);
	logic [31:0] error_status_reg;
	logic [31:0] error_address_reg;
	logic error_held;
	logic [31:0] crc_control_reg;
	logic [31:0] crc_value_reg;
	logic [31:0] crc_feedback_taps;
	logic [31:0] crc_state;
	logic [1:0] byte_order_select;
	logic write_reorder_enable;
	logic bit_reflect_select;
	logic [4:0] poly_length_field;
	logic crc_route_enable;
	logic crc_append_mode;
	logic crc_type_select;
	logic [2:0] crc_channel_select;
	logic dp_active;
	logic dp_write;
	logic [7:0] dp_addr;
	logic take;
	logic rd_stat;
	logic rd_addr;
	logic wr_ctrl;
	logic wr_value;
	logic wr_taps;
	logic wr_data_in;
	logic [31:0] next_control;
	logic [31:0] reordered;
	logic [31:0] crc_in;
	logic [31:0] next_crc;
	logic [31:0] poly_mask;
	logic [31:0] crc_view;
	logic beat;
	logic [31:0] beat_data;
	logic [16:0] ip_sum;

	assign byte_order_select = crc_control_reg[dma_crc_pkg::byte_order_select_lsb +: 2];
	assign write_reorder_enable = crc_control_reg[dma_crc_pkg::wbo_bit];
	assign bit_reflect_select = crc_control_reg[dma_crc_pkg::bit_reflect_select_bit];
	assign poly_length_field = crc_control_reg[dma_crc_pkg::poly_length_field_lsb +: 5];
	assign crc_route_enable = crc_control_reg[dma_crc_pkg::crc_route_enable_bit];
	assign crc_append_mode = crc_control_reg[dma_crc_pkg::app_bit];
	assign crc_type_select = crc_control_reg[dma_crc_pkg::typ_bit];
	assign crc_channel_select = crc_control_reg[dma_crc_pkg::ch_lsb +: 3];

	// Registers answer with zero wait states.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign take = hsel && hready && htrans[1];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dp_active <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_active <= take;
			dp_write <= hwrite;
			dp_addr <= haddr[7:0];
		end
	end

	assign rd_stat = take && !hwrite && haddr[7:0] == dma_crc_pkg::off_error_status;
	assign rd_addr = take && !hwrite && haddr[7:0] == dma_crc_pkg::off_error_address;
	assign wr_ctrl = dp_active && dp_write && dp_addr == dma_crc_pkg::off_crc_control;
	assign wr_value = dp_active && dp_write && dp_addr == dma_crc_pkg::off_crc_value;
	assign wr_taps = dp_active && dp_write && dp_addr == dma_crc_pkg::off_crc_taps;
	assign wr_data_in = dp_active && dp_write && dp_addr == dma_crc_pkg::off_data_in;

	// Read data is latched at the address phase so the clear-on-read can happen in the
	// same edge without losing the captured contents.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= dma_crc_pkg::reset_word;
		end else if (take && !hwrite) begin
			case (haddr[7:0])
				dma_crc_pkg::off_error_status: hrdata <= error_status_reg;
				dma_crc_pkg::off_error_address: hrdata <= error_address_reg;
				dma_crc_pkg::off_crc_control: hrdata <= crc_control_reg;
				dma_crc_pkg::off_crc_value: hrdata <= crc_view;
				dma_crc_pkg::off_crc_taps: hrdata <= crc_feedback_taps;
				default: hrdata <= dma_crc_pkg::reset_word;
			endcase
		end
	end

	// Error capture. A read of either register releases the hold, but an error arriving
	// in that very cycle is captured, so no fault is lost to the clear.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			error_status_reg <= dma_crc_pkg::reset_word;
			error_address_reg <= dma_crc_pkg::reset_word;
			error_held <= 1'b0;
		end else if ((rd_err || wr_err) && (!error_held || rd_stat || rd_addr)) begin
			error_held <= 1'b1;
			error_status_reg <= dma_crc_pkg::reset_word;
			error_status_reg[dma_crc_pkg::err_dir_bit] <= rd_err;
			error_status_reg[dma_crc_pkg::err_ch_lsb +: 3] <= active_channel;
			error_address_reg <= rd_err ? rd_err_addr : wr_err_addr;
		end else begin
			if (rd_stat) begin
				error_status_reg <= dma_crc_pkg::reset_word;
			end
			if (rd_addr) begin
				error_address_reg <= dma_crc_pkg::reset_word;
			end
			if (rd_stat || rd_addr) begin
				error_held <= 1'b0;
			end
		end
	end

	// Only implemented bits are stored; append cannot be set while write-reorder is on.
	always_comb begin
		next_control = hwdata & dma_crc_pkg::crc_control_mask;
		if (next_control[dma_crc_pkg::wbo_bit]) begin
			next_control[dma_crc_pkg::app_bit] = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc_control_reg <= dma_crc_pkg::reset_word;
		end else if (wr_ctrl) begin
			crc_control_reg <= next_control;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc_feedback_taps <= dma_crc_pkg::reset_word;
		end else if (wr_taps) begin
			crc_feedback_taps <= hwdata;
		end
	end

	// Byte reordering of a word.
	always_comb begin
		case (byte_order_select)
			dma_crc_pkg::byte_order_select_none: reordered = beat_data;
			dma_crc_pkg::byte_order_select_word:
				reordered = {beat_data[7:0], beat_data[15:8], beat_data[23:16], beat_data[31:24]};
			dma_crc_pkg::byte_order_select_half: reordered = {beat_data[15:0], beat_data[31:16]};
			dma_crc_pkg::byte_order_select_half_bytes:
				reordered = {beat_data[23:16], beat_data[31:24], beat_data[7:0], beat_data[15:8]};
			default: reordered = beat_data;
		endcase
	end

	// Software can push a word into the engine through the data-in register as well.
	assign beat_data = wr_data_in ? hwdata : xfer_data;
	assign crc_channel_active = crc_route_enable
		&& xfer_channel == crc_channel_select;
	assign beat = wr_data_in || (xfer_valid && crc_channel_active);

	// Mask of the bits within the polynomial length, at most 32 bits long.
	assign poly_mask = 32'hffffffff >> (5'h1f - poly_length_field);
	assign crc_view = crc_type_select ? {16'h0000, ~crc_state[15:0]} : (crc_state & poly_mask);

	// The engine is a bitwise Galois LFSR. The reflected form runs the register
	// downwards with the reflected tap pattern, which costs a bit reversal of the taps.
	always_comb begin
		logic fb;
		logic [31:0] taps_r;
		logic [31:0] st;
		fb = 1'b0;
		st = crc_state & poly_mask;
		taps_r = 32'h00000000;
		crc_in = reordered;
		ip_sum = 17'h00000;
		for (int i = 0; i < 32; i++) begin
			taps_r[i] = crc_feedback_taps[31 - i];
		end
		taps_r = (taps_r >> (5'h1f - poly_length_field)) & poly_mask;
		if (crc_type_select) begin
			// One's complement sum on 16-bit halves; reflection reverses each half.
			if (bit_reflect_select) begin
				for (int i = 0; i < 32; i++) begin
					crc_in[i] = reordered[(i & 16) + 15 - (i & 15)];
				end
			end
			ip_sum = {1'b0, crc_state[15:0]} + {1'b0, crc_in[15:0]};
			ip_sum = {1'b0, ip_sum[15:0]} + {16'h0000, ip_sum[16]};
			ip_sum = {1'b0, ip_sum[15:0]} + {1'b0, crc_in[31:16]};
			ip_sum = {1'b0, ip_sum[15:0]} + {16'h0000, ip_sum[16]};
			next_crc = {16'h0000, ip_sum[15:0]};
		end else if (bit_reflect_select) begin
			for (int i = 0; i < 32; i++) begin
				fb = st[0] ^ crc_in[i];
				st = st >> 1;
				if (fb) begin
					st = st ^ taps_r;
				end
			end
			next_crc = st;
		end else begin
			for (int i = 31; i >= 0; i--) begin
				fb = st[poly_length_field] ^ crc_in[i];
				st = (st << 1) & poly_mask;
				if (fb) begin
					st = st ^ (crc_feedback_taps & poly_mask);
				end
			end
			next_crc = st;
		end
	end

	// IP mode keeps the running sum uncomplemented; the value register shows its complement.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc_state <= dma_crc_pkg::reset_word;
		end else if (wr_value) begin
			crc_state <= crc_type_select ? {16'h0000, ~hwdata[15:0]} : hwdata;
		end else if (beat) begin
			crc_state <= next_crc;
		end
	end
	assign crc_value_reg = crc_view;

	// Destination side of the data path.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dest_valid <= 1'b0;
			dest_data <= dma_crc_pkg::reset_word;
			dest_addr <= dma_crc_pkg::reset_word;
			dest_is_crc <= 1'b0;
		end else if (block_done && crc_route_enable && crc_append_mode
				&& xfer_channel == crc_channel_select) begin
			dest_valid <= 1'b1;
			dest_data <= crc_value_reg;
			dest_addr <= channel_dest_start;
			dest_is_crc <= 1'b1;
		end else if (xfer_valid && !(crc_channel_active && crc_append_mode)) begin
			dest_valid <= 1'b1;
			dest_data <= (crc_channel_active && write_reorder_enable) ? reordered : xfer_data;
			dest_addr <= dma_crc_pkg::reset_word;
			dest_is_crc <= 1'b0;
		end else begin
			dest_valid <= 1'b0;
			dest_is_crc <= 1'b0;
		end
	end
endmodule

// file: test/dma_crc_checker.sv
`timescale 1ns/1ps
module dma_crc_checker (
	input wire logic clk, // Clock.
	input wire logic rst, // Reset.
	input wire logic hsel, // Select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Type.
	input wire logic hwrite, // Write.
	input wire logic hready, // Ready in.
	input wire logic [31:0] hrdata, // Read data.
	input wire logic hreadyout, // Ready out.
	input wire logic hresp, // Response.
	input wire logic rd_err, // Read fault.
	input wire logic wr_err, // Write fault.
	input wire logic xfer_valid, // Beat.
	input wire logic [31:0] xfer_data, // Beat data.
	input wire logic block_done, // Block end.
	input wire logic [31:0] channel_dest_start, // Target.
	input wire logic dest_valid, // Dest strobe.
	input wire logic [31:0] dest_data, // Dest data.
	input wire logic [31:0] dest_addr, // Dest address.
	input wire logic dest_is_crc, // CRC write.
	input wire logic crc_channel_active // Engine on.
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rd_take;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	wire st_rd = rd_take && haddr[7:0] == dma_crc_pkg::off_error_status;
	wire ad_rd = rd_take && haddr[7:0] == dma_crc_pkg::off_error_address;
	wire cc_rd = rd_take && haddr[7:0] == dma_crc_pkg::off_crc_control;
	wire un_rd = rd_take && haddr[7:0] == dma_crc_pkg::off_data_out;
	a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
	a_status_clear: assert property ((st_rd && !rd_err && !wr_err) ##1
		(!rd_take && !rd_err && !wr_err)[*2] ##1 st_rd |=> hrdata == 32'h0)
		else $error("status not cleared");
	a_address_clear: assert property ((ad_rd && !rd_err && !wr_err) ##1
		(!rd_take && !rd_err && !wr_err)[*2] ##1 ad_rd |=> hrdata == 32'h0)
		else $error("address not cleared");
	a_status_gaps: assert property (st_rd |=> (hrdata & 32'h7ffffff8) == 32'h0)
		else $error("status gap bits set");
	a_control_gaps: assert property (cc_rd |=>
		(hrdata & ~dma_crc_pkg::crc_control_mask) == 32'h0)
		else $error("control gap bits set");
	a_unmapped_zero: assert property (un_rd |=> hrdata == 32'h0) else $error("unmapped not zero");
	a_plain_copy: assert property (xfer_valid && !crc_channel_active |=> dest_valid
		&& !dest_is_crc && dest_data == $past(xfer_data)) else $error("plain beat altered");
	a_dest_cause: assert property (dest_valid |-> $past(xfer_valid) || $past(block_done))
		else $error("dest write without cause");
	a_crc_target: assert property (dest_valid && dest_is_crc |->
		dest_addr == $past(channel_dest_start))
		else $error("crc write address wrong");
	c_reread: cover property (st_rd ##1 (!rd_take)[*2] ##1 st_rd);
	c_append: cover property (dest_valid && dest_is_crc);
	c_both: cover property (rd_err && wr_err);
endmodule
bind dma_error_capture_crc_config dma_crc_checker i_chk (.clk(clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .rd_err(rd_err), .wr_err(wr_err),
	.xfer_valid(xfer_valid), .xfer_data(xfer_data), .block_done(block_done),
	.channel_dest_start(channel_dest_start), .dest_valid(dest_valid), .dest_data(dest_data),
	.dest_addr(dest_addr), .dest_is_crc(dest_is_crc), .crc_channel_active(crc_channel_active));

// file: test/bus_target_model.sv
`timescale 1ns/1ps
module bus_target_model (
	input wire logic clk, // Clock.
	input wire logic dest_valid, // Dest strobe.
	input wire logic [31:0] dest_data, // Dest data.
	input wire logic [31:0] dest_addr, // Dest address.
	input wire logic dest_is_crc, // CRC write.
	output logic rd_err = 1'b0, // Read fault.
	output logic [31:0] rd_err_addr = 32'h0, // Read address.
	output logic wr_err = 1'b0, // Write fault.
	output logic [31:0] wr_err_addr = 32'h0 // Write address.
);
	logic [31:0] last_data = 32'h0;
	logic [31:0] last_addr = 32'h0;
	logic last_crc = 1'b0;
	int writes = 0;
	always @(posedge clk) begin
		if (dest_valid === 1'b1) begin
			last_data <= dest_data;
			last_addr <= dest_addr;
			last_crc <= dest_is_crc;
			writes <= writes + 1;
		end
	end
	task fault(input logic r, input logic w, input logic [31:0] ra, input logic [31:0] wa);
		@(posedge clk);
		rd_err <= r;
		wr_err <= w;
		rd_err_addr <= ra;
		wr_err_addr <= wa;
		@(posedge clk);
		rd_err <= 1'b0;
		wr_err <= 1'b0;
		// Released address lines are inverted so a stale value cannot be mistaken for valid.
		rd_err_addr <= ~ra;
		wr_err_addr <= ~wa;
	endtask
endmodule

// file: test/test_dma_error_capture_crc_config.sv
`timescale 1ns/1ps
module test_dma_error_capture_crc_config;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, xfer_valid = 0, block_done = 0, act;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, xfer_data = 32'h0, rdv;
	logic [2:0] active_channel = 3'h0, xfer_channel = 3'h0;
	logic [31:0] hrdata, rd_err_addr, wr_err_addr, dest_data, dest_addr;
	logic hreadyout, hresp, rd_err, wr_err, dest_valid, dest_is_crc, crc_channel_active;
	int bad_count = 0, num_checks = 0, cycles = 0, n;
	localparam logic [31:0] dest_start = 32'h00002000;
	localparam logic [7:0] st = dma_crc_pkg::off_error_status, ad = dma_crc_pkg::off_error_address;
	localparam logic [7:0] cc = dma_crc_pkg::off_crc_control, cv = dma_crc_pkg::off_crc_value;
	dma_error_capture_crc_config i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rd_err(rd_err),
		.rd_err_addr(rd_err_addr), .wr_err(wr_err), .wr_err_addr(wr_err_addr),
		.active_channel(active_channel), .xfer_channel(xfer_channel), .xfer_valid(xfer_valid),
		.xfer_data(xfer_data), .block_done(block_done), .channel_dest_start(dest_start),
		.dest_valid(dest_valid), .dest_data(dest_data), .dest_addr(dest_addr),
		.dest_is_crc(dest_is_crc), .crc_channel_active(crc_channel_active));
	bus_target_model i_tgt (.clk(clk), .dest_valid(dest_valid), .dest_data(dest_data),
		.dest_addr(dest_addr), .dest_is_crc(dest_is_crc), .rd_err(rd_err),
		.rd_err_addr(rd_err_addr), .wr_err(wr_err), .wr_err_addr(wr_err_addr));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			test_done();
		end
	end
	task test_done;
		if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= dma_crc_pkg::htrans_nonseq;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdv);
	endtask
	task beat(input logic [2:0] ch, input logic [31:0] d, input logic done);
		@(posedge clk);
		xfer_valid <= !done;
		block_done <= done;
		xfer_channel <= ch;
		xfer_data <= d;
		#1 act = crc_channel_active;
		@(posedge clk);
		xfer_valid <= 1'b0;
		block_done <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task t_reset;
		logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
		foreach (offs[i]) rd(offs[i], 32'h0);
	endtask
	task t_capture;
		active_channel <= 3'h5;
		i_tgt.fault(1'b1, 1'b0, 32'h10000abc, 32'h0);
		rd(st, 32'h80000005);
		rd(st, 32'h0);
		rd(ad, 32'h10000abc);
		rd(ad, 32'h0);
	endtask
	task t_hold;
		active_channel <= 3'h3;
		i_tgt.fault(1'b1, 1'b1, 32'h0000aa00, 32'h0000bb00);
		active_channel <= 3'h6;
		i_tgt.fault(1'b0, 1'b1, 32'h0, 32'h0000cc00);
		rd(st, 32'h80000003);
		rd(ad, 32'h0000aa00);
		i_tgt.fault(1'b0, 1'b1, 32'h0, 32'hfffffffc);
		rd(st, 32'h00000006);
		rd(ad, 32'hfffffffc);
	endtask
	task t_control;
		bus(1'b1, cc, 32'hffffffff);
		rd(cc, 32'h39001fa7);
		bus(1'b1, cc, 32'h00000040);
		rd(cc, 32'h00000040);
		bus(1'b1, dma_crc_pkg::off_crc_taps, 32'ha5a5a5a5);
		rd(dma_crc_pkg::off_crc_taps, 32'ha5a5a5a5);
		bus(1'b1, cc, 32'h00000700);
		bus(1'b1, cv, 32'hffffffff);
		rd(cv, 32'h000000ff);
		bus(1'b1, cc, 32'h00001f00);
		bus(1'b1, cv, 32'hffffffff);
		rd(cv, 32'hffffffff);
	endtask
	task t_engine;
		bus(1'b1, dma_crc_pkg::off_crc_taps, 32'h00000007);
		bus(1'b1, cc, 32'h00000700);
		bus(1'b1, cv, 32'h00000000);
		bus(1'b1, dma_crc_pkg::off_data_in, 32'h00000003);
		rd(cv, 32'h00000009);
		bus(1'b1, cc, 32'h01000700);
		bus(1'b1, cv, 32'h00000000);
		bus(1'b1, dma_crc_pkg::off_data_in, 32'hc0000000);
		rd(cv, 32'h00000090);
		bus(1'b1, cc, 32'h01000020);
		bus(1'b1, cv, 32'h0000ffff);
		bus(1'b1, dma_crc_pkg::off_data_in, 32'h00010001);
		rd(cv, 32'h0000fffe);
	endtask
	task t_reorder;
		logic [31:0] e [4] = '{32'h11223344, 32'h44332211, 32'h33441122, 32'h22114433};
		for (int b = 0; b < 4; b++) begin
			bus(1'b1, cc, 32'h08000082 | (32'(b) << 28));
			beat(3'h2, 32'h11223344, 1'b0);
			chk("dest data", e[b], i_tgt.last_data);
			chk("engine on", 32'h1, {31'h0, act});
		end
		beat(3'h1, 32'h11223344, 1'b0);
		chk("other channel", 32'h0, {31'h0, act});
		bus(1'b1, cc, 32'h10000082);
		beat(3'h2, 32'h11223344, 1'b0);
		chk("no reorder", 32'h11223344, i_tgt.last_data);
		bus(1'b1, cc, 32'h00000002);
		beat(3'h2, 32'h55667788, 1'b0);
		chk("bypass", 32'h0, {31'h0, act});
	endtask
	task t_append;
		bus(1'b1, cc, 32'h000003e4);
		bus(1'b1, cv, 32'h0000ffff);
		n = i_tgt.writes;
		beat(3'h4, 32'h00010002, 1'b0);
		chk("append writes", 32'(n), 32'(i_tgt.writes));
		beat(3'h4, 32'h0, 1'b1);
		chk("crc addr", dest_start, i_tgt.last_addr);
		chk("crc flag", 32'h1, {31'h0, i_tgt.last_crc});
		chk("crc value", 32'h0000fffc, i_tgt.last_data);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_capture();
		t_hold();
		t_control();
		t_engine();
		t_reorder();
		t_append();
		test_done();
	end
endmodule
